// file: hw/break_trace_pkg.sv
// shared constants and types for the break and trace event unit
package break_trace_pkg;
   localparam int NUM_EVENTS   = 8;
   localparam int ADDR_W       = 20;
   localparam int DATA_W       = 16;
   localparam int PASS_W       = 8;
   localparam int TS_W         = 24;
   localparam int TRACE_DEPTH  = 8;
   localparam int SEQ_STATES   = 4;
   localparam logic [1:0] SEQ_BREAK_STATE = 2'h3;
   localparam logic [PASS_W-1:0] PASS_ONE = 8'h01;
   localparam logic [PASS_W-1:0] PASS_RESET = 8'h01;
   localparam logic [TS_W-1:0] TS_RESET = 24'h000000;
   localparam logic [2:0] QUEUE_MAX = 3'h4;
   localparam logic BUS_WIDTH_16 = 1'b1;
   // trace record field positions, low to high
   localparam int TR_TS_LSB    = 0;
   localparam int TR_EXT_LSB   = TR_TS_LSB + TS_W;
   localparam int TR_QN_LSB    = TR_EXT_LSB + 8;
   localparam int TR_CPU_LSB   = TR_QN_LSB + 3;
   localparam int TR_RW_LSB    = TR_CPU_LSB + 3;
   localparam int TR_BUS_LSB   = TR_RW_LSB + 2;
   localparam int TR_VALID_LSB = TR_BUS_LSB + 3;
   localparam int TR_UBE_LSB   = TR_VALID_LSB + 1;
   localparam int TR_WIDTH_LSB = TR_UBE_LSB + 1;
   localparam int TR_DATA_LSB  = TR_WIDTH_LSB + 1;
   localparam int TR_ADDR_LSB  = TR_DATA_LSB + DATA_W;
   localparam int TRACE_W      = TR_ADDR_LSB + ADDR_W;

   typedef enum logic [2:0] {EV_FETCH, EV_DATA, EV_BIT, EV_INTERRUPT, EV_TRIGGER} event_kind_t;
   typedef enum logic [1:0] {COMB_AND, COMB_SAME_TIME, COMB_OR, COMB_STATE} combine_mode_t;
   typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EITHER} access_cond_t;
   typedef enum logic [1:0] {RW_NONE, RW_READ, RW_WRITE} rw_code_t;
   typedef enum logic [2:0] {BUS_IDLE, BUS_NON_CPU, BUS_INT_ACK, CPU_CODE_BYTE_READ,
                             CPU_CODE_WORD_READ, CPU_DATA_BYTE_ACCESS,
                             CPU_DATA_WORD_ACCESS} bus_unit_t;
   typedef enum logic [2:0] {OPCODE_BYTE_READ, OPCODE_WORD_READ, OPERAND_BYTE_READ,
                             OPERAND_WORD_READ, QUEUE_FLUSH_STATUS} cpu_status_t;
endpackage

// file: hw/stream_if.sv
// valid/ready stream carrier between the unit and its trace fifo
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: hw/trace_fifo.sv
// flip-flop fifo for trace records with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module trace_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   stream_if.sink   wr,
   stream_if.source rd
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0]      count, next_count;
   logic             push, pop;

   // full and empty come straight from the count
   assign wr.ready = (count != (PW+1)'(DEPTH));
   assign rd.valid = (count != '0);
   assign rd.data  = mem[rd_ptr];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   // pointer wrap works for depths that are not a power of two
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      next_count = count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // storage has no reset, only written on push
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr] <= wr.data;
   end
endmodule // trace_fifo
`default_nettype wire

// file: hw/break_trace_event_unit.sv
// event detection, break control and trace capture for the emulator
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - hardware break halts only after the breakpoint instruction completes
// - event kinds detect instruction fetch, data access and bit access
// - interrupt event fires on interrupt entry and on interrupt completion
// - trigger event fires from external trace inputs, not bus activity
// - eight fetch address conditions, each single address or range
// - eight masked data conditions, each single value or range
// - data events qualified by read, write or either
// - and mode breaks once all enabled events occurred, any order
// - same-time mode breaks when all enabled events match one cycle
// - or mode breaks when any enabled event occurs
// - state mode walks a sequence and breaks entering break state
// - pass count 1 to 255 matches needed before event counts occurred
// - same-time mode forces every pass count to one
// - no hardware break while global enable is cleared
// - software break stops before the marked statement executes
// - free run suppresses software and hardware breaks
// - trace record holds address, data and a 16-bit bus width
// - trace records upper byte enable, low means odd byte valid
// - trace records active-low bus cycle valid flag
// - trace records bus unit status code per cycle
// - trace records cpu to bus unit status code
// - trace records instruction queue byte count, 0 to 4
// - trace samples eight external trace input levels
// - trace carries timestamp from start of user program
module break_trace_event_unit
   import break_trace_pkg::*;
#(
   parameter int EVENTS     = NUM_EVENTS,
   parameter int FIFO_DEPTH = TRACE_DEPTH
) (
   input  wire logic                clk,
   input  wire logic                reset_n,
   // target bus and cpu view
   input  wire logic [ADDR_W-1:0]   bus_addr,
   input  wire logic [DATA_W-1:0]   bus_data,
   input  wire logic                bus_write,
   input  wire logic                upper_byte_enable_n,
   input  wire logic                bus_cycle_valid_n,
   input  wire bus_unit_t           bus_unit,
   input  wire cpu_status_t         cpu_status,
   input  wire logic [2:0]          queue_byte_count,
   input  wire logic                bit_access,
   input  wire logic                irq_taken,
   input  wire logic                irq_done,
   input  wire logic                insn_complete,
   input  wire logic                sw_break_hit,
   input  wire logic [7:0]          external_trace_inputs,
   // run control
   input  wire logic                run_start,
   input  wire logic                free_run,
   input  wire logic                hw_break_enable,
   input  wire combine_mode_t       combine_mode,
   // per event setup
   input  wire logic [EVENTS-1:0]   event_enable,
   input  wire event_kind_t         event_kind   [EVENTS],
   input  wire logic [ADDR_W-1:0]   addr_low     [EVENTS],
   input  wire logic [ADDR_W-1:0]   addr_high    [EVENTS],
   input  wire logic [DATA_W-1:0]   data_low     [EVENTS],
   input  wire logic [DATA_W-1:0]   data_high    [EVENTS],
   input  wire logic [DATA_W-1:0]   data_mask    [EVENTS],
   input  wire access_cond_t        access_cond  [EVENTS],
   input  wire logic [PASS_W-1:0]   pass_count   [EVENTS],
   input  wire logic [2:0]          state_event  [SEQ_STATES-1],
   // status and results
   output logic                     halt,
   output logic                     sw_break_taken,
   output logic                     hw_break_taken,
   output logic [EVENTS-1:0]        event_occurred,
   output logic                     trace_overflow,
   output logic                     trace_valid,
   output logic [TRACE_W-1:0]       trace_data,
   input  wire logic                trace_ready
);
   typedef enum logic [1:0] {BRK_OFF, BRK_RUN, BRK_PEND, BRK_STOP} brk_state_t;

   brk_state_t              state, next_state;
   logic [PASS_W-1:0]       pass_left [EVENTS];
   logic [PASS_W-1:0]       next_pass_left [EVENTS];
   logic [EVENTS-1:0]       next_occurred;
   logic [EVENTS-1:0]       ev_match, hit;
   logic [1:0]              seq_state, next_seq_state;
   logic [TS_W-1:0]         timestamp, next_timestamp;
   logic                    next_halt, next_sw_taken, next_hw_taken, next_overflow;
   logic                    hw_fire, running, any_enabled;
   logic [TRACE_W-1:0]      record;
   rw_code_t                rw_code;

   stream_if #(.WIDTH(TRACE_W)) push_if ();
   stream_if #(.WIDTH(TRACE_W)) pop_if ();

   // inclusive range check, single value when low equals high
   function automatic logic in_range(input logic [ADDR_W-1:0] v,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // masked data range, masked-off byte lanes never disturb the compare
   function automatic logic data_hit(input logic [DATA_W-1:0] v,
                                     input logic [DATA_W-1:0] lo,
                                     input logic [DATA_W-1:0] hi,
                                     input logic [DATA_W-1:0] m);
      data_hit = ((v & m) >= (lo & m)) && ((v & m) <= (hi & m));
   endfunction

   assign running = (state == BRK_RUN) || (state == BRK_PEND);

   // raw per-event match against the current cycle
   always_comb begin
      for (int i = 0; i < EVENTS; i++) begin
         ev_match[i] = 1'b0;
         unique case (event_kind[i])
            EV_FETCH: ev_match[i] = !bus_cycle_valid_n &&
               (bus_unit == CPU_CODE_BYTE_READ || bus_unit == CPU_CODE_WORD_READ) &&
               in_range(bus_addr, addr_low[i], addr_high[i]);
            EV_DATA: ev_match[i] = !bus_cycle_valid_n &&
               (bus_unit == CPU_DATA_BYTE_ACCESS || bus_unit == CPU_DATA_WORD_ACCESS) &&
               in_range(bus_addr, addr_low[i], addr_high[i]) &&
               data_hit(bus_data, data_low[i], data_high[i], data_mask[i]) &&
               ((access_cond[i] == ACC_EITHER) ||
                (access_cond[i] == ACC_WRITE && bus_write) ||
                (access_cond[i] == ACC_READ && !bus_write));
            EV_BIT: ev_match[i] = !bus_cycle_valid_n && bit_access &&
               in_range(bus_addr, addr_low[i], addr_high[i]);
            EV_INTERRUPT: ev_match[i] = irq_taken || irq_done;
            EV_TRIGGER: ev_match[i] = ((external_trace_inputs ^ data_low[i][7:0])
               & data_mask[i][7:0]) == 8'h00;
            default: ev_match[i] = 1'b0;
         endcase
      end
   end

   // pass counters: reload on arm, count down, latch occurrence
   always_comb begin
      for (int i = 0; i < EVENTS; i++) begin
         hit[i] = running && event_enable[i] && ev_match[i] && !event_occurred[i] &&
                  (pass_left[i] == PASS_ONE);
         next_pass_left[i] = pass_left[i];
         next_occurred[i]  = event_occurred[i];
         if (run_start) begin
            // a programmed zero is treated as one so the event can still fire
            next_pass_left[i] = (combine_mode == COMB_SAME_TIME || pass_count[i] == '0)
                                ? PASS_ONE : pass_count[i];
            next_occurred[i]  = 1'b0;
         end else if (hit[i]) begin
            next_occurred[i] = 1'b1;
         end else if (running && event_enable[i] && ev_match[i] && !event_occurred[i]) begin
            next_pass_left[i] = pass_left[i] - PASS_ONE;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < EVENTS; i++) pass_left[i] <= PASS_RESET;
         event_occurred <= '0;
      end else begin
         for (int i = 0; i < EVENTS; i++) pass_left[i] <= next_pass_left[i];
         event_occurred <= next_occurred;
      end
   end

   // sequence walker for state mode and the combination decision
   always_comb begin
      any_enabled    = |event_enable;
      next_seq_state = seq_state;
      if (run_start) begin
         next_seq_state = '0;
      end else if (seq_state != SEQ_BREAK_STATE && hit[state_event[seq_state]]) begin
         next_seq_state = seq_state + 2'h1;
      end
      unique case (combine_mode)
         COMB_AND:       hw_fire = any_enabled &&
                                   ((next_occurred | ~event_enable) == '1);
         COMB_SAME_TIME: hw_fire = any_enabled && running &&
                                   ((ev_match | ~event_enable) == '1);
         COMB_OR:        hw_fire = |hit;
         COMB_STATE:     hw_fire = (seq_state != SEQ_BREAK_STATE) &&
                                   (next_seq_state == SEQ_BREAK_STATE);
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) seq_state <= '0;
      else seq_state <= next_seq_state;
   end

   // run and break control; halt flop mirrors the stop state
   always_comb begin
      next_state    = state;
      next_sw_taken = sw_break_taken;
      next_hw_taken = hw_break_taken;
      if (run_start) begin
         next_state    = BRK_RUN;
         next_sw_taken = 1'b0;
         next_hw_taken = 1'b0;
      end else begin
         unique case (state)
            BRK_OFF: next_state = BRK_OFF;
            BRK_RUN: begin
               if (sw_break_hit && !free_run) begin
                  next_state    = BRK_STOP;
                  next_sw_taken = 1'b1;
               end else if (hw_fire && hw_break_enable && !free_run) begin
                  next_state = BRK_PEND;
               end
            end
            BRK_PEND: begin
               // the target finishes the matched instruction before stopping
               if (insn_complete) begin
                  next_state    = BRK_STOP;
                  next_hw_taken = 1'b1;
               end
            end
            BRK_STOP: next_state = BRK_STOP;
         endcase
      end
      next_halt = (next_state == BRK_STOP);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state          <= BRK_OFF;
         halt           <= 1'b0;
         sw_break_taken <= 1'b0;
         hw_break_taken <= 1'b0;
      end else begin
         state          <= next_state;
         halt           <= next_halt;
         sw_break_taken <= next_sw_taken;
         hw_break_taken <= next_hw_taken;
      end
   end

   // trace record assembly; address and data mean nothing when cycle invalid
   always_comb begin
      rw_code = bus_cycle_valid_n ? RW_NONE : (bus_write ? RW_WRITE : RW_READ);
      record  = '0;
      record[TR_ADDR_LSB +: ADDR_W] = bus_addr;
      record[TR_DATA_LSB +: DATA_W] = bus_data;
      record[TR_WIDTH_LSB]          = BUS_WIDTH_16;
      record[TR_UBE_LSB]            = upper_byte_enable_n;
      record[TR_VALID_LSB]          = bus_cycle_valid_n;
      record[TR_BUS_LSB +: 3]       = bus_unit;
      record[TR_RW_LSB +: 2]        = rw_code;
      record[TR_CPU_LSB +: 3]       = cpu_status;
      record[TR_QN_LSB +: 3]        = (queue_byte_count > QUEUE_MAX) ?
                                      QUEUE_MAX : queue_byte_count;
      record[TR_EXT_LSB +: 8]       = external_trace_inputs;
      record[TR_TS_LSB +: TS_W]     = timestamp;
   end

   // a full fifo drops the cycle; the sticky flag tells software the trace has a gap
   assign push_if.valid = running;
   assign push_if.data  = record;

   always_comb begin
      next_timestamp = timestamp;
      if (run_start) next_timestamp = TS_RESET;
      else if (running) next_timestamp = timestamp + 1'b1;
      next_overflow = trace_overflow;
      if (run_start) next_overflow = 1'b0;
      if (running && !push_if.ready) next_overflow = 1'b1;                        // set wins
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timestamp      <= TS_RESET;
         trace_overflow <= 1'b0;
      end else begin
         timestamp      <= next_timestamp;
         trace_overflow <= next_overflow;
      end
   end

   trace_fifo #(.WIDTH(TRACE_W), .DEPTH(FIFO_DEPTH)) u_trace_fifo (
      .clk     (clk),
      .reset_n (reset_n),
      .wr      (push_if.sink),
      .rd      (pop_if.source)
   );

   // output register stage so trace ports come straight from flops
   assign pop_if.ready = !trace_valid || trace_ready;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trace_valid <= 1'b0;
         trace_data  <= '0;
      end else if (pop_if.ready) begin
         trace_valid <= pop_if.valid;
         trace_data  <= pop_if.data;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_pend_wait;
      state == BRK_PEND && !insn_complete && !run_start;
   endsequence
   sequence s_run_two;
      state == BRK_RUN && !run_start ##1 state == BRK_RUN && !run_start;
   endsequence

   a_sw_break_stops: assert property (
      state == BRK_RUN && !run_start && sw_break_hit && !free_run |=> halt && sw_break_taken)
      else $error("software break did not halt next cycle");
   a_free_run_quiet: assert property (
      state == BRK_RUN && !run_start && free_run |=> !halt && state != BRK_PEND)
      else $error("break taken during free run");
   a_hw_waits_insn: assert property (
      s_pend_wait |=> !halt)
      else $error("hardware break halted before instruction completed");
   a_pend_then_halt: assert property (
      state == BRK_PEND && insn_complete && !run_start |=>
      halt && hw_break_taken ##1 (halt || $past(run_start)))
      else $error("hardware break did not halt after completion");
   a_enable_gates: assert property (
      $rose(state == BRK_PEND) |-> $past(hw_break_enable))
      else $error("hardware break armed while disabled");
   a_or_mode_fires: assert property (
      state == BRK_RUN && !run_start && combine_mode == COMB_OR && hw_break_enable &&
      !free_run && !sw_break_hit && |hit |=> state == BRK_PEND)
      else $error("or mode missed an event");
   a_same_time_pass: assert property (
      run_start && combine_mode == COMB_SAME_TIME |=> pass_left[0] == PASS_ONE)
      else $error("same-time mode pass count not one");
   a_rw_idle_cycle: assert property (
      bus_cycle_valid_n |-> record[TR_RW_LSB +: 2] == RW_NONE)
      else $error("read/write column set in invalid cycle");
   a_timestamp_step: assert property (
      s_run_two |-> timestamp == $past(timestamp) + 1'b1)
      else $error("timestamp did not advance while running");
   a_pass_countdown: assert property (
      running && !run_start && event_enable[0] && ev_match[0] && !event_occurred[0] &&
      pass_left[0] > PASS_ONE |=> pass_left[0] == $past(pass_left[0]) - PASS_ONE)
      else $error("pass counter did not decrement");
endmodule // break_trace_event_unit
`default_nettype wire

// file: test/target_model.sv
// behavioural target bus unit: one bus cycle per request, inverted idle
`timescale 1ns/10ps
`default_nettype none
module target_model
   import break_trace_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              req,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_data,
   input  wire logic              req_write,
   input  wire bus_unit_t         req_unit,
   input  wire logic              done_req,
   output logic [ADDR_W-1:0]      bus_addr,
   output logic [DATA_W-1:0]      bus_data,
   output logic                   bus_write,
   output logic                   bus_cycle_valid_n,
   output bus_unit_t              bus_unit,
   output logic                   insn_complete
);
   // idle cycles show inverted values so stale data never reads as a match
   always @(posedge clk) begin
      bus_cycle_valid_n <= !req;
      bus_addr          <= req ? req_addr : ~req_addr;
      bus_data          <= req ? req_data : ~req_data;
      bus_write         <= req ? req_write : !req_write;
      bus_unit          <= req ? req_unit : BUS_IDLE;
      insn_complete     <= done_req; // caller picks a prompt or slow finish
   end
endmodule // target_model
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the break and trace event unit
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import break_trace_pkg::*;
;
   logic clk = 0, reset_n = 0, req = 0, req_write = 0, done_req = 0, bit_access = 0;
   logic irq_taken = 0, irq_done = 0, sw_hit = 0, run_start = 0, free_run = 0, hw_en = 1;
   logic trace_ready = 1, ube_n, halt, sw_bt, hw_bt, ovf, tv, halt_q, ts_ok = 0;
   logic bus_write, valid_n, insn_complete;
   logic [ADDR_W-1:0] req_addr = '0, a, bus_addr;
   logic [DATA_W-1:0] req_data = '0, bus_data;
   logic [7:0] ext, en = '0, occ;
   logic [2:0] qn;
   logic [TS_W-1:0] last_ts;
   logic [TRACE_W-1:0] td;
   logic [1:0] notes [$];
   logic [40:0] bq [$], e;
   bus_unit_t req_unit = BUS_IDLE, bus_unit;
   cpu_status_t cpu;
   combine_mode_t mode = COMB_OR;
   event_kind_t kind [8] = '{default: EV_FETCH};
   access_cond_t acc [8] = '{default: ACC_EITHER};
   logic [ADDR_W-1:0] alo [8] = '{default: '0}, ahi [8] = '{default: '0};
   logic [DATA_W-1:0] dlo [8] = '{default: '0}, dhi [8] = '{default: '0}, dm [8] = '{default: '0};
   logic [PASS_W-1:0] pc [8] = '{default: PASS_ONE};
   logic [2:0] se [3] = '{3'h0, 3'h1, 3'h2};
   int num_errors = 0, n_tests = 0;

   break_trace_event_unit i_break_trace_event_unit (.clk, .reset_n, .bus_addr, .bus_data,
      .bus_write, .upper_byte_enable_n(ube_n), .bus_cycle_valid_n(valid_n), .bus_unit,
      .cpu_status(cpu), .queue_byte_count(qn), .bit_access, .irq_taken, .irq_done,
      .insn_complete, .sw_break_hit(sw_hit), .external_trace_inputs(ext), .run_start,
      .free_run, .hw_break_enable(hw_en), .combine_mode(mode), .event_enable(en),
      .event_kind(kind), .addr_low(alo), .addr_high(ahi), .data_low(dlo), .data_high(dhi),
      .data_mask(dm), .access_cond(acc), .pass_count(pc), .state_event(se), .halt,
      .sw_break_taken(sw_bt), .hw_break_taken(hw_bt), .event_occurred(occ),
      .trace_overflow(ovf), .trace_valid(tv), .trace_data(td), .trace_ready);
   target_model i_target_model (.clk, .req, .req_addr, .req_data, .req_write, .req_unit,
      .done_req, .bus_addr, .bus_data, .bus_write, .bus_cycle_valid_n(valid_n), .bus_unit,
      .insn_complete);

   initial forever #25 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   // one event slot: address range a..a+4, data value d under mask m
   task automatic ev(int i, event_kind_t k, logic [15:0] d, m, access_cond_t c, logic [7:0] p);
      @(posedge clk);
      kind[i] <= k;
      alo[i] <= a;
      ahi[i] <= a + 4;
      dlo[i] <= d;
      dhi[i] <= d;
      dm[i] <= m;
      acc[i] <= c;
      pc[i] <= p;
   endtask
   task automatic run(combine_mode_t m, logic [7:0] e);
      @(posedge clk);
      mode <= m;
      en <= e;
      run_start <= 1;
      @(posedge clk);
      run_start <= 0;
      cyc(2);
   endtask
   // bit strobe lines up with the bus cycle as the unit samples it
   task automatic bus(logic [19:0] ad, logic [15:0] d, logic w, bus_unit_t u, logic b);
      @(posedge clk);
      bq.push_back({ad, d, u, w ? RW_WRITE : RW_READ});
      req <= 1;
      req_addr <= ad;
      req_data <= d;
      req_write <= w;
      req_unit <= u;
      @(posedge clk);
      req <= 0;
      bit_access <= b;
      @(posedge clk);
      bit_access <= 0;
   endtask
   // a nonzero note is the stop cause expected once the instruction completes
   task automatic done(logic [1:0] note, string s);
      if (note) notes.push_back(note);
      cyc(3);
      done_req <= 1;
      @(posedge clk);
      done_req <= 0;
      cyc(6);
      $display("test %s finished", s);
   endtask

   // each stop is paired with the oldest noted cause, an unnoted stop fails
   always @(posedge clk) begin
      halt_q <= halt;
      if (halt === 1'h1 && halt_q === 1'h0)
         chk({sw_bt, hw_bt}, notes.size() ? notes.pop_front() : 2'h0);
   end
   // timestamp step skipped over restarts (back to zero) and after drops
   always @(posedge clk) if (tv && trace_ready) begin
      chk(td[45], 1'h1);
      chk(td[44], ube_n);
      chk(td[31:24], ext);
      chk(td[34:32], qn > 3'h4 ? 3'h4 : qn);
      chk(td[37:35], cpu);
      if (td[43]) chk(td[39:38], RW_NONE);
      else begin
         // each valid bus cycle pairs with the oldest noted request
         e = bq.size() ? bq.pop_front() : '1;
         chk(td[81:62], e[40:21]);
         chk(td[61:46], e[20:5]);
         chk(td[42:38], e[4:0]);
      end
      if (ts_ok && td[23:0] != 0 && !ovf) chk(td[23:0], last_ts + 1'h1);
      last_ts <= td[23:0];
      ts_ok <= 1;
   end
   initial begin
      #(3000 * 50);
      num_errors++;
      final_report;
   end

   initial begin
      void'($urandom(32'haad4e83b));
      ext <= $urandom;
      ube_n <= $urandom;
      qn <= $urandom_range(7);
      cpu <= cpu_status_t'($urandom_range(4));
      a = $urandom_range(20'hffff0);
      cyc(6);
      reset_n <= 1;
      ev(0, EV_FETCH, 16'h0, 16'h0, ACC_EITHER, 8'h03);
      run(COMB_OR, 8'h01);
      bus(a + 9, 16'h0, 0, CPU_CODE_WORD_READ, 0);
      bus(a + 2, 16'h0, 0, CPU_CODE_BYTE_READ, 0);
      bus(a, 16'h0, 0, CPU_CODE_WORD_READ, 0);
      cyc(2);
      chk(occ, 8'h00);
      bus(a + 3, 16'h0, 0, CPU_CODE_WORD_READ, 0);
      cyc(6);
      chk(occ, 8'h01);
      chk(halt, 1'h0);
      done(2'h1, "pass count");
      ev(1, EV_DATA, 16'h5400, 16'hff00, ACC_WRITE, 8'h01);
      ev(0, EV_FETCH, 16'h0, 16'h0, ACC_EITHER, 8'h01);
      run(COMB_AND, 8'h03);
      bus(a, 16'h54aa, 0, CPU_DATA_WORD_ACCESS, 0);
      bus(a, 16'h55cd, 1, CPU_DATA_WORD_ACCESS, 0);
      bus(a, 16'h54cd, 1, CPU_DATA_BYTE_ACCESS, 0);
      cyc(3);
      chk(occ, 8'h02);
      chk(halt, 1'h0);
      bus(a + 1, 16'h0, 0, CPU_CODE_BYTE_READ, 0);
      done(2'h1, "and mode");
      ev(0, EV_FETCH, 16'h0, 16'h0, ACC_EITHER, 8'h05);
      ev(1, EV_BIT, 16'h0, 16'h0, ACC_EITHER, 8'h05);
      run(COMB_SAME_TIME, 8'h03);
      bus(a, 16'h0, 0, CPU_CODE_WORD_READ, 0);
      bus(a + 1, 16'h0, 0, BUS_IDLE, 1);
      done(2'h0, "same time apart");
      chk(halt, 1'h0);
      chk(occ, 8'h03);
      bus(a, 16'h0, 0, CPU_CODE_WORD_READ, 1);
      done(2'h1, "same time together");
      // an event latches once per run, so each step needs its own event
      ev(0, EV_FETCH, 16'h0, 16'h0, ACC_EITHER, 8'h01);
      ev(1, EV_BIT, 16'h0, 16'h0, ACC_EITHER, 8'h01);
      ev(2, EV_DATA, 16'h0, 16'h0, ACC_READ, 8'h01);
      run(COMB_STATE, 8'h07);
      bus(a, 16'h0, 0, CPU_CODE_WORD_READ, 0);
      bus(a + 1, 16'h0, 0, BUS_IDLE, 1);
      done(2'h0, "state two steps");
      chk(halt, 1'h0);
      bus(a, 16'h0, 0, CPU_DATA_BYTE_ACCESS, 0);
      done(2'h1, "state break");
      hw_en <= 0;
      ev(0, EV_INTERRUPT, 16'h0, 16'h0, ACC_EITHER, 8'h01);
      ev(2, EV_TRIGGER, {8'h00, ext}, 16'h00ff, ACC_EITHER, 8'h01);
      run(COMB_OR, 8'h07);
      irq_done <= 1;
      cyc(1);
      irq_done <= 0;
      bus(a + 1, 16'h0, 0, BUS_IDLE, 1);
      done(2'h0, "interrupt trigger bit");
      chk(occ, 8'h07);
      chk(halt, 1'h0);
      hw_en <= 1;
      free_run <= 1;
      run(COMB_OR, 8'h01);
      sw_hit <= 1;
      irq_taken <= 1;
      cyc(1);
      sw_hit <= 0;
      irq_taken <= 0;
      done(2'h0, "free run");
      chk(occ[0], 1'h1);
      chk(halt, 1'h0);
      free_run <= 0;
      trace_ready <= 0;
      cyc(14);
      chk(tv, 1'h1);
      chk(ovf, 1'h1);
      notes.push_back(2'h2);
      sw_hit <= 1;
      cyc(1);
      sw_hit <= 0;
      cyc(4);
      trace_ready <= 1;
      cyc(30);
      chk(tv, 1'h0);
      chk(notes.size() + bq.size(), 0);
      $display("test overflow and drain finished");
      final_report;
   end
endmodule // tb_top
`default_nettype wire
